// file: core/ssa_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the
//          stream attribute status registers.
// Assumes: Byte offsets on a 12-bit register port, one 32-bit word each.
// Notes:   Definitions only.
`ifndef SSA_PARAMS_SVH
`define SSA_PARAMS_SVH

// Register byte offsets
`define SSA_OFF_S3_FMT     12'h5A8
`define SSA_OFF_S3_FLAGS   12'h5AC
`define SSA_OFF_S3_M       12'h5B0
`define SSA_OFF_S3_N       12'h5B4
`define SSA_OFF_S3_BLANK_ID 12'h5B8
`define SSA_OFF_S4_HRES    12'h5C0
`define SSA_OFF_S4_HSPOL   12'h5C4
`define SSA_OFF_S4_HSWIDTH 12'h5C8
`define SSA_OFF_S4_HSTART  12'h5CC
`define SSA_OFF_S4_HTOTAL  12'h5D0
`define SSA_OFF_S4_VHEIGHT 12'h5D4
`define SSA_OFF_S4_VSPOL   12'h5D8
`define SSA_OFF_S4_VSWIDTH 12'h5DC
`define SSA_OFF_S4_VSTART  12'h5E0
`define SSA_OFF_S4_VTOTAL  12'h5E4

// Colour format fields
`define SSA_FMT_DEPTH_HI   7
`define SSA_FMT_DEPTH_LO   5
`define SSA_FMT_COLORIM    4
`define SSA_FMT_QRANGE     3
`define SSA_FMT_COMP_HI    2
`define SSA_FMT_COMP_LO    1
`define SSA_FMT_CLKMODE    0

// Secondary flags fields
`define SSA_FLG_RSVD_HI    6
`define SSA_FLG_RSVD_LO    3
`define SSA_FLG_STEREO_HI  2
`define SSA_FLG_STEREO_LO  1
`define SSA_FLG_EVEN       0

// Reset values and unmapped answer
`define SSA_RST_VAL        32'h0000_0000
`define SSA_UNMAPPED_VAL   32'h0000_0000

// Cycles from read request to read data
`define SSA_READ_LATENCY   1

`endif

// file: core/ssa_pkg.sv
// Purpose: Types of the stream attribute status registers.
// Assumes: Attribute packets arrive already parsed, one whole packet per cycle.
// Notes:   Stream numbers are 3 bits wide.
package ssa_pkg;

  // Component format encodings
  typedef enum logic [1:0] {
    SSA_COMP_RGB = 2'h0,
    SSA_COMP_422 = 2'h1,
    SSA_COMP_444 = 2'h2,
    SSA_COMP_RSV = 2'h3
  } ssa_comp_fmt_t;

  // One parsed main stream attribute packet
  typedef struct packed {
    logic [2:0]  stream;
    logic [7:0]  colour_format_attribute;
    logic [7:0]  secondary_flags_attribute;
    logic [23:0] clock_recovery_m;
    logic [23:0] clock_recovery_n;
    logic [15:0] hres;
    logic        hspol;
    logic [14:0] hswidth;
    logic [15:0] hstart;
    logic [15:0] htotal;
    logic [15:0] vheight;
    logic        vspol;
    logic [14:0] vswidth;
    logic [15:0] vstart;
    logic [15:0] vtotal;
  } ssa_attr_pkt_t;

  // One received vertical blanking identifier
  typedef struct packed {
    logic [2:0] stream;
    logic [7:0] vertical_blanking_identifier;
  } ssa_blank_id_t;

  // Register port request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ssa_req_t;

endpackage

// file: core/ssa_regs.sv
// Purpose: Read-only status registers holding the received main stream
//          attributes of stream 3 (tail) and stream 4 (timing).
// Assumes: Packet and blanking identifier inputs are parsed elsewhere, synchronous to
//          i_core_clk; one read answer per request, one cycle later.
// Notes:   Writes are accepted and dropped; unmapped reads return zero.
`timescale 1ns/1ps
`default_nettype none
`include "ssa_params.svh"

module ssa_regs
  import ssa_pkg::*;
#(
  parameter logic [2:0] TAIL_STREAM = 3'h3,
  parameter logic [2:0] TIMING_STREAM = 3'h4
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_pkt_valid,
  input wire ssa_attr_pkt_t i_pkt,
  input wire logic i_blank_id_valid,
  input wire ssa_blank_id_t i_blank_id,
  input wire ssa_req_t i_req,
  output logic [31:0] o_rd_data,
  output logic o_rd_valid
);

  // Elaboration check: the two register groups must face distinct streams
  if (TAIL_STREAM == TIMING_STREAM) begin : g_bad_streams
    $error("ssa_regs: TAIL_STREAM and TIMING_STREAM must differ");
  end

  // Stream 3 tail registers
  logic [7:0] s3_fmt;
  logic [2:0] s3_flags_lo;
  logic s3_flags_hi;
  logic [23:0] s3_m;
  logic [23:0] s3_n;
  logic [7:0] s3_blank_id;
  // Stream 4 timing registers
  logic [15:0] s4_hres;
  logic s4_hspol;
  logic [14:0] s4_hswidth;
  logic [15:0] s4_hstart;
  logic [15:0] s4_htotal;
  logic [15:0] s4_vheight;
  logic s4_vspol;
  logic [14:0] s4_vswidth;
  logic [15:0] s4_vstart;
  logic [15:0] s4_vtotal;

  logic take_s3;
  logic take_s4;
  logic take_blank_id;
  logic [31:0] next_rd_data;

  // Packets are steered only to the group of their own stream
  assign take_s3 = i_ce && i_pkt_valid && (i_pkt.stream == TAIL_STREAM);
  assign take_s4 = i_ce && i_pkt_valid && (i_pkt.stream == TIMING_STREAM);
  assign take_blank_id = i_ce && i_blank_id_valid && (i_blank_id.stream == TAIL_STREAM);

  // Stream 3 colour format, flags and clock recovery values
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s3_fmt <= 8'h00;
      s3_flags_hi <= 1'b0;
      s3_flags_lo <= 3'h0;
      s3_m <= 24'h00_0000;
      s3_n <= 24'h00_0000;
    end else if (take_s3) begin
      s3_fmt <= i_pkt.colour_format_attribute;
      s3_flags_hi <= i_pkt.secondary_flags_attribute[7];
      s3_flags_lo <= i_pkt.secondary_flags_attribute[2:0];
      s3_m <= i_pkt.clock_recovery_m;
      s3_n <= i_pkt.clock_recovery_n;
    end
  end

  // Latest blanking identifier of stream 3
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s3_blank_id <= 8'h00;
    end else if (take_blank_id) begin
      s3_blank_id <= i_blank_id.vertical_blanking_identifier;
    end
  end

  // Stream 4 horizontal timing
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s4_hres <= 16'h0000;
      s4_hspol <= 1'b0;
      s4_hswidth <= 15'h0000;
      s4_hstart <= 16'h0000;
      s4_htotal <= 16'h0000;
    end else if (take_s4) begin
      s4_hres <= i_pkt.hres;
      s4_hspol <= i_pkt.hspol;
      s4_hswidth <= i_pkt.hswidth;
      s4_hstart <= i_pkt.hstart;
      s4_htotal <= i_pkt.htotal;
    end
  end

  // Stream 4 vertical timing
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s4_vheight <= 16'h0000;
      s4_vspol <= 1'b0;
      s4_vswidth <= 15'h0000;
      s4_vstart <= 16'h0000;
      s4_vtotal <= 16'h0000;
    end else if (take_s4) begin
      s4_vheight <= i_pkt.vheight;
      s4_vspol <= i_pkt.vspol;
      s4_vswidth <= i_pkt.vswidth;
      s4_vstart <= i_pkt.vstart;
      s4_vtotal <= i_pkt.vtotal;
    end
  end

  // Address decode to a read word; narrow fields sit low, upper bits zero
  function automatic logic [31:0] read_word(input logic [11:0] addr);
    logic [31:0] w;
    w = `SSA_UNMAPPED_VAL;
    case (addr)
      `SSA_OFF_S3_FMT: w = {24'h00_0000, s3_fmt};
      `SSA_OFF_S3_FLAGS: w = {24'h00_0000, s3_flags_hi, 4'h0, s3_flags_lo};
      `SSA_OFF_S3_M: w = {8'h00, s3_m};
      `SSA_OFF_S3_N: w = {8'h00, s3_n};
      `SSA_OFF_S3_BLANK_ID: w = {24'h00_0000, s3_blank_id};
      `SSA_OFF_S4_HRES: w = {16'h0000, s4_hres};
      `SSA_OFF_S4_HSPOL: w = {31'h0000_0000, s4_hspol};
      `SSA_OFF_S4_HSWIDTH: w = {17'h0_0000, s4_hswidth};
      `SSA_OFF_S4_HSTART: w = {16'h0000, s4_hstart};
      `SSA_OFF_S4_HTOTAL: w = {16'h0000, s4_htotal};
      `SSA_OFF_S4_VHEIGHT: w = {16'h0000, s4_vheight};
      `SSA_OFF_S4_VSPOL: w = {31'h0000_0000, s4_vspol};
      `SSA_OFF_S4_VSWIDTH: w = {17'h0_0000, s4_vswidth};
      `SSA_OFF_S4_VSTART: w = {16'h0000, s4_vstart};
      `SSA_OFF_S4_VTOTAL: w = {16'h0000, s4_vtotal};
      default: w = `SSA_UNMAPPED_VAL;
    endcase
    return w;
  endfunction

  // Read word for the current request
  always_comb begin
    next_rd_data = read_word(i_req.addr);
  end

  // Read answer one cycle after the request; writes leave no trace
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= `SSA_RST_VAL;
      o_rd_valid <= 1'b0;
    end else if (i_ce) begin
      o_rd_valid <= i_req.rd;
      if (i_req.rd) begin
        o_rd_data <= next_rd_data;
      end
    end
  end

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_fmt_depth: assert property (take_s3 |=> s3_fmt[7:5] == $past(i_pkt.colour_format_attribute[7:5]))
    else $error("colour depth not captured");
  a_fmt_colorim: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S3_FMT
    |=> o_rd_valid && o_rd_data[`SSA_FMT_COLORIM] == $past(s3_fmt[4]))
    else $error("colorimetry bit misread");
  a_fmt_qrange: assert property (take_s3 ##1 (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S3_FMT)
    |=> o_rd_data[`SSA_FMT_QRANGE] == $past(i_pkt.colour_format_attribute[3], 2))
    else $error("quantisation range misread");
  a_fmt_comp: assert property (take_s3 |=> ssa_comp_fmt_t'(s3_fmt[2:1]) ==
    ssa_comp_fmt_t'($past(i_pkt.colour_format_attribute[2:1])))
    else $error("component format not captured");
  a_fmt_clkmode: assert property (take_s3 |=> s3_fmt[0] == $past(i_pkt.colour_format_attribute[0]))
    else $error("clock mode not captured");
  a_flags_reserved: assert property ($past(i_ce && i_req.rd) && $past(i_req.addr) == `SSA_OFF_S3_FLAGS
    |-> o_rd_data[6:3] == 4'h0)
    else $error("reserved flag bits not zero");
  a_flags_stereo: assert property (take_s3 |=> s3_flags_lo[2:1] == $past(i_pkt.secondary_flags_attribute[2:1]))
    else $error("stereo indication not captured");
  a_flags_even: assert property (take_s3 |=> s3_flags_lo[0] == $past(i_pkt.secondary_flags_attribute[0]))
    else $error("even line flag not captured");
  a_m_value: assert property (take_s3 ##1 (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S3_M)
    |=> o_rd_data == {8'h00, $past(i_pkt.clock_recovery_m, 2)})
    else $error("M value misread");
  a_n_value: assert property (take_s3 ##1 (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S3_N)
    |=> o_rd_data == {8'h00, $past(i_pkt.clock_recovery_n, 2)})
    else $error("N value misread");
  a_blank_latest: assert property (take_blank_id |=>
    s3_blank_id == $past(i_blank_id.vertical_blanking_identifier))
    else $error("blanking identifier not latest");
  a_blank_hold: assert property (!take_blank_id |=> $stable(s3_blank_id))
    else $error("blanking identifier changed unprompted");
  a_hres_read: assert property (take_s4 ##1 (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S4_HRES)
    |=> o_rd_data == {16'h0000, $past(i_pkt.hres, 2)})
    else $error("pixels per line misread");
  a_hspol_cap: assert property (take_s4 |=> s4_hspol == $past(i_pkt.hspol))
    else $error("hsync polarity not captured");
  a_hswidth_read: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S4_HSWIDTH
    |=> o_rd_data[31:15] == 17'h0_0000 && o_rd_data[14:0] == $past(s4_hswidth))
    else $error("hsync width misread");
  a_hstart_cap: assert property (take_s4 |=> s4_hstart == $past(i_pkt.hstart))
    else $error("horizontal start not captured");
  a_htotal_cap: assert property (take_s4 |=> s4_htotal == $past(i_pkt.htotal))
    else $error("line total not captured");
  a_vheight_cap: assert property (take_s4 |=> s4_vheight == $past(i_pkt.vheight))
    else $error("active lines not captured");
  a_vspol_read: assert property (take_s4 ##1 (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S4_VSPOL)
    |=> o_rd_data == {31'h0000_0000, $past(i_pkt.vspol, 2)})
    else $error("vsync polarity misread");
  a_vswidth_cap: assert property (take_s4 |=> s4_vswidth == $past(i_pkt.vswidth))
    else $error("vsync width not captured");
  a_vstart_cap: assert property (take_s4 |=> s4_vstart == $past(i_pkt.vstart))
    else $error("vertical start not captured");
  a_vtotal_cap: assert property (take_s4 |=> s4_vtotal == $past(i_pkt.vtotal))
    else $error("frame lines not captured");
  a_other_stream: assert property (!take_s4 |=> $stable(s4_htotal) && $stable(s4_vtotal))
    else $error("timing changed without own packet");
  a_tail_other: assert property (!take_s3 |=> $stable(s3_m) && $stable(s3_fmt))
    else $error("tail changed without own packet");
  a_read_latency: assert property (i_ce && i_req.rd |=> o_rd_valid)
    else $error("read answer missing");

  // Read words: each offset answers its own register, as held at the taking edge
  a_fmt_word: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S3_FMT
    |=> o_rd_data == {24'h00_0000, $past(s3_fmt)})
    else $error("colour format word misread");
  a_flags_word: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S3_FLAGS
    |=> o_rd_data[2:0] == $past(s3_flags_lo))
    else $error("secondary flags word misread");
  a_m_word: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S3_M
    |=> o_rd_data == {8'h00, $past(s3_m)})
    else $error("M word misread");
  a_n_word: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S3_N
    |=> o_rd_data == {8'h00, $past(s3_n)})
    else $error("N word misread");
  a_blank_word: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S3_BLANK_ID
    |=> o_rd_data == {24'h00_0000, $past(s3_blank_id)})
    else $error("blanking identifier word misread");
  a_hres_word: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S4_HRES
    |=> o_rd_data == {16'h0000, $past(s4_hres)})
    else $error("pixels per line word misread");
  a_hspol_word: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S4_HSPOL
    |=> o_rd_data == {31'h0000_0000, $past(s4_hspol)})
    else $error("hsync polarity word misread");
  a_hstart_word: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S4_HSTART
    |=> o_rd_data == {16'h0000, $past(s4_hstart)})
    else $error("horizontal start word misread");
  a_htotal_word: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S4_HTOTAL
    |=> o_rd_data == {16'h0000, $past(s4_htotal)})
    else $error("line total word misread");
  a_vheight_word: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S4_VHEIGHT
    |=> o_rd_data == {16'h0000, $past(s4_vheight)})
    else $error("active lines word misread");
  a_vspol_word: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S4_VSPOL
    |=> o_rd_data == {31'h0000_0000, $past(s4_vspol)})
    else $error("vsync polarity word misread");
  a_vswidth_word: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S4_VSWIDTH
    |=> o_rd_data == {17'h0_0000, $past(s4_vswidth)})
    else $error("vsync width word misread");
  a_vstart_word: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S4_VSTART
    |=> o_rd_data == {16'h0000, $past(s4_vstart)})
    else $error("vertical start word misread");
  a_vtotal_word: assert property (i_ce && i_req.rd && i_req.addr == `SSA_OFF_S4_VTOTAL
    |=> o_rd_data == {16'h0000, $past(s4_vtotal)})
    else $error("frame lines word misread");

  // Holes in the map answer zero, so a host never sees stale data there
  a_hole_zero: assert property (i_ce && i_req.rd && i_req.addr == 12'h5BC
    |=> o_rd_data == `SSA_UNMAPPED_VAL)
    else $error("unmapped word not zero");

  // A lone write touches neither registers nor the answer
  a_write_ignored: assert property (i_ce && i_req.wr && !i_req.rd && !i_pkt_valid
    && !i_blank_id_valid |=> $stable(s3_fmt) && $stable(s4_hres) && !o_rd_valid)
    else $error("write left a trace");

  // The answer strobe drops when no read is taken
  a_valid_drop: assert property (i_ce && !i_req.rd |=> !o_rd_valid)
    else $error("read answer without request");

  // A low enable freezes the answer and every register
  a_freeze_out: assert property (!i_ce |=> $stable(o_rd_data) && $stable(o_rd_valid))
    else $error("answer moved while disabled");
  a_freeze_tail: assert property (!i_ce |=> $stable(s3_m) && $stable(s3_n)
    && $stable(s3_blank_id))
    else $error("tail moved while disabled");
  a_freeze_timing: assert property (!i_ce |=> $stable(s4_hres) && $stable(s4_vheight)
    && $stable(s4_vswidth))
    else $error("timing moved while disabled");

endmodule // ssa_regs
`default_nettype wire

// file: bench/ssa_tx_model.sv
// Purpose: Upstream transmitter model that delivers attribute packets and blanking ids.
// Assumes: One-cycle valid pulses, changed just after the rising edge.
// Notes:   Released payload lines show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module ssa_tx_model
  import ssa_pkg::*;
(
  input wire logic i_core_clk,
  output var logic o_pkt_valid,
  output var ssa_attr_pkt_t o_pkt,
  output var logic o_blank_id_valid,
  output var ssa_blank_id_t o_blank_id
);
  // Idle lines at time zero
  initial begin
    o_pkt_valid = 1'b0;
    o_pkt = '0;
    o_blank_id_valid = 1'b0;
    o_blank_id = '0;
  end

  // Whole packet in one cycle, then payload released
  task automatic send_pkt(input ssa_attr_pkt_t p);
    @(posedge i_core_clk);
    o_pkt_valid <= 1'b1;
    o_pkt <= p;
    @(posedge i_core_clk);
    o_pkt_valid <= 1'b0;
    o_pkt <= ~p; // Stale payload never looks valid
  endtask

  // One blanking identifier, then released
  task automatic send_blank_id(input ssa_blank_id_t v);
    @(posedge i_core_clk);
    o_blank_id_valid <= 1'b1;
    o_blank_id <= v;
    @(posedge i_core_clk);
    o_blank_id_valid <= 1'b0;
    o_blank_id <= ~v;
  endtask
endmodule // ssa_tx_model
`default_nettype wire

// file: bench/tb_ssa_regs.sv
// Purpose: Self-checking bench for the stream attribute status registers.
// Assumes: Read answer registered at the taking edge itself; reset values zero.
// Notes:   Expected words are built here from the field layout.
`timescale 1ns/1ps
`default_nettype none
`include "ssa_params.svh"
module tb_ssa_regs
  import ssa_pkg::*;
;
  logic clk;
  logic rst;
  logic ce;
  logic pkt_valid;
  ssa_attr_pkt_t pkt;
  logic blank_id_valid;
  ssa_blank_id_t blank_id;
  ssa_req_t req;
  logic [31:0] rd_data;
  logic rd_valid;
  int fails = 0;
  int num_checks = 0;
  logic [11:0] offs [15];
  logic [31:0] exp_v [15];
  ssa_attr_pkt_t p;

  ssa_regs dut (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_pkt_valid(pkt_valid),
    .i_pkt(pkt), .i_blank_id_valid(blank_id_valid), .i_blank_id(blank_id), .i_req(req),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid));

  ssa_tx_model u_tx (.i_core_clk(clk), .o_pkt_valid(pkt_valid), .o_pkt(pkt),
    .o_blank_id_valid(blank_id_valid), .o_blank_id(blank_id));

  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // One read, answer checked just after the answering edge
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    req.addr <= ~a;
    #1;
    num_checks++;
    if (rd_valid !== 1'b1 || rd_data !== e) begin
      fails++;
      $display("MISMATCH reg %h expected %h seen %h valid %b", a, e, rd_data, rd_valid);
    end
  endtask

  // One write pulse, which the block must drop
  task automatic wr_req(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
    req.wdata <= ~d;
  endtask

  // Reads every mapped register against the expected table
  task automatic check_all();
    for (int i = 0; i < 15; i++) rd_chk(offs[i], exp_v[i]);
  endtask

  // Prints counts and verdict, ends the run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #25000;
    fails++;
    print_verdict();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    req = '0;
    offs = '{`SSA_OFF_S3_FMT, `SSA_OFF_S3_FLAGS, `SSA_OFF_S3_M, `SSA_OFF_S3_N,
      `SSA_OFF_S3_BLANK_ID, `SSA_OFF_S4_HRES, `SSA_OFF_S4_HSPOL, `SSA_OFF_S4_HSWIDTH,
      `SSA_OFF_S4_HSTART, `SSA_OFF_S4_HTOTAL, `SSA_OFF_S4_VHEIGHT, `SSA_OFF_S4_VSPOL,
      `SSA_OFF_S4_VSWIDTH, `SSA_OFF_S4_VSTART, `SSA_OFF_S4_VTOTAL};
    exp_v = '{default: 32'h0000_0000};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    check_all();
    rd_chk(12'h5BC, 32'h0000_0000);
    rd_chk(12'h5E8, 32'h0000_0000);
    // Tail packet with timing fields that stream 4 must not take
    u_tx.send_pkt('{3'h3, 8'hB5, 8'hFF, 24'hABCDEF, 24'h123456, 16'h1111, 1'b1, 15'h2222,
      16'h3333, 16'h4444, 16'h5555, 1'b1, 15'h6666, 16'h7777, 16'h8888});
    u_tx.send_blank_id('{3'h3, 8'h5A});
    u_tx.send_blank_id('{3'h4, 8'hC3});
    exp_v[0:4] = '{32'h0000_00B5, 32'h0000_0087, 32'h00AB_CDEF, 32'h0012_3456, 32'h0000_005A};
    check_all();
    // Timing packet, boundary widths, tail fields that stream 3 must not take
    u_tx.send_pkt('{3'h4, 8'h00, 8'h00, 24'h0, 24'h0, 16'h0780, 1'b1, 15'h7FFF, 16'hFFFF,
      16'h0898, 16'h0438, 1'b1, 15'h0005, 16'h0029, 16'h0465});
    exp_v[5:14] = '{32'h0000_0780, 32'h0000_0001, 32'h0000_7FFF, 32'h0000_FFFF,
      32'h0000_0898, 32'h0000_0438, 32'h0000_0001, 32'h0000_0005, 32'h0000_0029, 32'h0000_0465};
    check_all();
    // Foreign stream, disabled clock and host writes all leave registers alone
    u_tx.send_pkt('1);
    @(posedge clk);
    ce <= 1'b0;
    u_tx.send_pkt('{default: '0, stream: 3'h4});
    ce <= 1'b1;
    for (int i = 0; i < 15; i++) wr_req(offs[i], 32'hFFFF_FFFF);
    check_all();
    // Every component format code, with colorimetry, range and clock mode toggled
    p = '0;
    p.stream = 3'h3;
    for (int c = 0; c < 4; c++) begin
      p.colour_format_attribute = {3'h5, c[0], ~c[0], c[1:0], c[1]};
      u_tx.send_pkt(p);
      rd_chk(`SSA_OFF_S3_FMT, {24'h0, 3'h5, c[0], ~c[0], c[1:0], c[1]});
    end
    print_verdict();
  end
endmodule // tb_ssa_regs
`default_nettype wire
